// ==== rtl/dic_map.vh ====
`ifndef DIC_MAP_VH
`define DIC_MAP_VH
// register offsets (word index on the plain register port)
`define DIC_OFF_CH_CFG0 4'h0
`define DIC_OFF_CH_CFG1 4'h1
`define DIC_OFF_CH_CFG2 4'h2
`define DIC_OFF_CH_CFG3 4'h3
`define DIC_OFF_THRESH 4'h4
`define DIC_OFF_PIN_CFG 4'h5
`define DIC_OFF_STATE 4'h6
`define DIC_OFF_FUNC 4'h7
`define DIC_OFF_DRIVE0 4'h8
`define DIC_OFF_DRIVE1 4'h9
`define DIC_OFF_DRIVE2 4'hA
`define DIC_OFF_DRIVE3 4'hB
// input_channel_config fields
`define DIC_CFG_DEB_LSB 0
`define DIC_CFG_DEB_MSB 4
`define DIC_CFG_MODE_BIT 5
`define DIC_CFG_INV_BIT 6
`define DIC_CFG_SRC_BIT 7
`define DIC_CFG_COMP_EN_BIT 8
`define DIC_CFG_SINK_LSB 9
`define DIC_CFG_SINK_MSB 12
`define DIC_CFG_RESET 16'h0000
// threshold_config fields
`define DIC_THR_CODE_LSB 0
`define DIC_THR_CODE_MSB 4
`define DIC_THR_REF_BIT 5
`define DIC_THR_RESET 16'h0000
// channel function codes
`define DIC_FUNC_HIZ 2'h0
`define DIC_FUNC_DIN_LOGIC 2'h1
`define DIC_FUNC_DIN_LOOP 2'h2
// output pin config per channel: 2 bits
`define DIC_PIN_LOW 2'h0
`define DIC_PIN_HIGH 2'h1
`define DIC_PIN_DIN 2'h2
// sink current: 120 uA steps up to 1.8 mA
`define DIC_SINK_STEP_UA 120
`define DIC_SINK_MAX_UA 1800
`define DIC_SINK_MAX_CODE 4'hF
// sampling clock: ~800 ns at a 5 ns core clock
`define DIC_SAMPLE_NS 800
`define DIC_CLK_NS 5
`define DIC_SAMPLE_DIV (`DIC_SAMPLE_NS / `DIC_CLK_NS)
`define DIC_THR_ANALOG_SUPPLY_MAX 5'h1D
`endif

// ==== rtl/dic_channel_top.v ====
// Behaviour
// - per channel, software picks raw or filtered terminal voltage for comparator
// - final input states readable in a status register
// - each channel pin can drive its debounced input state
// - per channel sink current code, 0 to 1.8 mA in 120 uA steps
// - one bit selects supply or external reference for threshold DAC
// - threshold code is a five-bit field
// - fixed reference: threshold 0.5 V plus code times 0.5 V, all codes
// - comparator sampled every ~800 ns; samples feed debounce counter
// - five-bit debounce time; code zero bypasses the debouncer
// - codes 01 to 1F map to fixed durations from table
// - per channel mode bit selects counting mode 0 (default) or 1
// - mode 0: up/down count per sample, update output at target
// - mode 0: count starts on difference, direction reverses on return
// - mode 1: count after change until target, then toggle and clear
// - mode 1: clear count when sample equals current output
// - invert bit inverts debounced state before status register
// - loop powered mode sources current limited by drive code
// - result always goes to status register, and also to pins where pin config selects it
// - selecting a digital input function sets comparator on, sink off
`timescale 1ns/1ps
`default_nettype none
`include "dic_map.vh"
module dic_channel_top (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // analog front end: comparator results for raw and filtered sense
  input wire [3:0] unfiltered_terminal_sense,
  input wire [3:0] filtered_terminal_sense,
  // analog controls
  output reg [3:0] sense_select,
  output reg [3:0] comparator_enable,
  output reg [15:0] sink_code,
  output reg threshold_reference_select,
  output reg [4:0] threshold_code,
  output reg [3:0] loop_source_enable,
  output reg [51:0] loop_current_limit,
  // per channel output pins
  output reg [3:0] channel_output_pin
);

  reg [15:0] cfg_q [0:3];
  reg [15:0] thr_q;
  reg [7:0] pin_cfg_q;
  reg [7:0] func_q;
  reg [12:0] drive_q [0:3];
  reg [7:0] div_q;
  reg tick_q;
  reg [3:0] deb_q;
  reg [16:0] cnt_q [0:3];
  reg [3:0] state_q;
  integer i;

  // debounce duration lookup in 800 ns samples, rounded to nearest
  // 17 bits so the longest duration (about 94k samples) fits without saturating
  function [16:0] dic_target;
    input [4:0] code;
    begin
      case (code)
        5'h01: dic_target = 17'h00010;
        5'h02: dic_target = 17'h00017;
        5'h03: dic_target = 17'h0001E;
        5'h04: dic_target = 17'h00029;
        5'h05: dic_target = 17'h00035;
        5'h06: dic_target = 17'h00046;
        5'h07: dic_target = 17'h0005E;
        5'h08: dic_target = 17'h0007E;
        5'h09: dic_target = 17'h000A3;
        5'h0A: dic_target = 17'h000E2;
        5'h0B: dic_target = 17'h0012D;
        5'h0C: dic_target = 17'h00190;
        5'h0D: dic_target = 17'h0020D;
        5'h0E: dic_target = 17'h002BC;
        5'h0F: dic_target = 17'h003AA;
        5'h10: dic_target = 17'h004E3;
        5'h11: dic_target = 17'h0065A;
        5'h12: dic_target = 17'h008CB;
        5'h13: dic_target = 17'h00BB9;
        5'h14: dic_target = 17'h00FA1;
        5'h15: dic_target = 17'h01483;
        5'h16: dic_target = 17'h01B5A;
        5'h17: dic_target = 17'h0249F;
        5'h18: dic_target = 17'h030D4;
        5'h19: dic_target = 17'h03F7A;
        5'h1A: dic_target = 17'h057E4;
        5'h1B: dic_target = 17'h07530;
        5'h1C: dic_target = 17'h09C41;
        5'h1D: dic_target = 17'h0CD15;
        5'h1E: dic_target = 17'h11170;
        5'h1F: dic_target = 17'h16E36;
        default: dic_target = 17'h00000;
      endcase
    end
  endfunction

  reg [3:0] sample_d;
  reg [3:0] shown;
  always @*
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      sample_d[i] = cfg_q[i][`DIC_CFG_SRC_BIT] ? filtered_terminal_sense[i]
                                              : unfiltered_terminal_sense[i];
      shown[i] = (cfg_q[i][`DIC_CFG_DEB_MSB:`DIC_CFG_DEB_LSB] == 5'h00) ? sample_d[i]
                                                                        : deb_q[i];
    end
  end

  // register writes; a digital input function select loads comparator on and sink off
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        cfg_q[i] <= `DIC_CFG_RESET;
        drive_q[i] <= 13'h0000;
      end
      thr_q <= `DIC_THR_RESET;
      pin_cfg_q <= 8'h00;
      func_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `DIC_OFF_CH_CFG0, `DIC_OFF_CH_CFG1, `DIC_OFF_CH_CFG2, `DIC_OFF_CH_CFG3:
          cfg_q[reg_addr[1:0]] <= {3'h0, reg_wdata[12:0]};
        `DIC_OFF_THRESH: thr_q <= {10'h000, reg_wdata[5:0]};
        `DIC_OFF_PIN_CFG: pin_cfg_q <= reg_wdata[7:0];
        `DIC_OFF_FUNC:
        begin
          func_q <= reg_wdata[7:0];
          for (i = 0; i < 4; i = i + 1)
            if (reg_wdata[2*i +: 2] == `DIC_FUNC_DIN_LOGIC ||
                reg_wdata[2*i +: 2] == `DIC_FUNC_DIN_LOOP)
            begin
              cfg_q[i][`DIC_CFG_COMP_EN_BIT] <= 1'b1;
              cfg_q[i][`DIC_CFG_SINK_MSB:`DIC_CFG_SINK_LSB] <= 4'h0;
            end
        end
        `DIC_OFF_DRIVE0, `DIC_OFF_DRIVE1, `DIC_OFF_DRIVE2, `DIC_OFF_DRIVE3:
          drive_q[reg_addr[1:0]] <= reg_wdata[12:0];
        default: ;
      endcase
    end
  end

  // sample clock divider: one tick per ~800 ns
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == 8'd0);
      div_q <= (div_q == (`DIC_SAMPLE_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end

  // debouncers
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      deb_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        cnt_q[i] <= 17'h00000;
    end
    else if (tick_q)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        if (cfg_q[i][`DIC_CFG_DEB_MSB:`DIC_CFG_DEB_LSB] == 5'h00)
        begin
          deb_q[i] <= sample_d[i];
          cnt_q[i] <= 17'h00000;
        end
        else if (!cfg_q[i][`DIC_CFG_MODE_BIT])
        begin
          // mode 0: count toward the new level, back down when it returns
          if (sample_d[i] != deb_q[i])
          begin
            if (cnt_q[i] + 17'h00001 >= dic_target(cfg_q[i][4:0]))
            begin
              deb_q[i] <= sample_d[i];
              cnt_q[i] <= 17'h00000;
            end
            else
              cnt_q[i] <= cnt_q[i] + 17'h00001;
          end
          else if (cnt_q[i] != 17'h00000)
            cnt_q[i] <= cnt_q[i] - 17'h00001;
        end
        else
        begin
          if (sample_d[i] == deb_q[i])
            cnt_q[i] <= 17'h00000;
          else if (cnt_q[i] + 17'h00001 >= dic_target(cfg_q[i][4:0]))
          begin
            deb_q[i] <= ~deb_q[i];
            cnt_q[i] <= 17'h00000;
          end
          else
            cnt_q[i] <= cnt_q[i] + 17'h00001;
        end
      end
    end
  end

  // status, read port and pin / analog outputs
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= 4'h0;
      reg_rdata <= 16'h0000;
      channel_output_pin <= 4'h0;
      sense_select <= 4'h0;
      comparator_enable <= 4'h0;
      sink_code <= 16'h0000;
      threshold_reference_select <= 1'b0;
      threshold_code <= 5'h00;
      loop_source_enable <= 4'h0;
      loop_current_limit <= 52'h0;
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        state_q[i] <= shown[i] ^ cfg_q[i][`DIC_CFG_INV_BIT];
        case (pin_cfg_q[2*i +: 2])
          `DIC_PIN_HIGH: channel_output_pin[i] <= 1'b1;
          `DIC_PIN_DIN: channel_output_pin[i] <= shown[i] ^ cfg_q[i][`DIC_CFG_INV_BIT];
          default: channel_output_pin[i] <= 1'b0;
        endcase
        sense_select[i] <= cfg_q[i][`DIC_CFG_SRC_BIT];
        comparator_enable[i] <= cfg_q[i][`DIC_CFG_COMP_EN_BIT];
        sink_code[4*i +: 4] <= (cfg_q[i][12:9] > `DIC_SINK_MAX_CODE) ? `DIC_SINK_MAX_CODE
                                                                       : cfg_q[i][12:9];
        loop_source_enable[i] <= (func_q[2*i +: 2] == `DIC_FUNC_DIN_LOOP);
        loop_current_limit[13*i +: 13] <= drive_q[i];
      end
      threshold_reference_select <= thr_q[`DIC_THR_REF_BIT];
      threshold_code <= thr_q[`DIC_THR_CODE_MSB:`DIC_THR_CODE_LSB];
      if (reg_rd)
      begin
        case (reg_addr)
          `DIC_OFF_CH_CFG0, `DIC_OFF_CH_CFG1, `DIC_OFF_CH_CFG2, `DIC_OFF_CH_CFG3:
            reg_rdata <= cfg_q[reg_addr[1:0]];
          `DIC_OFF_THRESH: reg_rdata <= thr_q;
          `DIC_OFF_PIN_CFG: reg_rdata <= {8'h00, pin_cfg_q};
          `DIC_OFF_STATE: reg_rdata <= {12'h000, state_q};
          `DIC_OFF_FUNC: reg_rdata <= {8'h00, func_q};
          `DIC_OFF_DRIVE0, `DIC_OFF_DRIVE1, `DIC_OFF_DRIVE2, `DIC_OFF_DRIVE3:
            reg_rdata <= {3'h0, drive_q[reg_addr[1:0]]};
          default: reg_rdata <= 16'h0000;
        endcase
      end
      else
        reg_rdata <= 16'h0000;
    end
  end

endmodule // dic_channel_top
`default_nettype wire

// ==== testbench/dic_channel_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module dic_channel_props (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // register port
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // analog controls and pins
  input wire [3:0] sense_select,
  input wire [3:0] comparator_enable,
  input wire [15:0] sink_code,
  input wire threshold_reference_select,
  input wire [4:0] threshold_code,
  input wire [3:0] loop_source_enable,
  input wire [51:0] loop_current_limit,
  input wire [3:0] channel_output_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire w0 = reg_wr && reg_addr == 4'h0;
  wire wf = reg_wr && reg_addr == 4'h7;
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  // register takes the write at the strobe edge, outputs follow one edge later
  property p_src; w0 |-> ##2 sense_select[0] == $past(reg_wdata[7], 2); endproperty
  property p_sink; w0 |-> ##2 sink_code[3:0] == $past(reg_wdata[12:9], 2); endproperty
  property p_thr;
    reg_wr && reg_addr == 4'h4 |-> ##2
      {threshold_reference_select, threshold_code} == $past(reg_wdata[5:0], 2);
  endproperty
  property p_func;
    wf && reg_wdata[1:0] == 2'h1 |-> ##2 comparator_enable[0] && sink_code[3:0] == 4'h0;
  endproperty
  property p_loop;
    wf |-> ##2 loop_source_enable[0] == ($past(reg_wdata[1:0], 2) == 2'h2);
  endproperty
  property p_drive;
    reg_wr && reg_addr == 4'h8 |-> ##2 loop_current_limit[12:0] == $past(reg_wdata[12:0], 2);
  endproperty
  property p_pin;
    reg_wr && reg_addr == 4'h5 && reg_wdata[1:0] == 2'h1 |-> ##2 channel_output_pin[0];
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_src: assert property (p_src) else $error("source select wrong");
  a_sink: assert property (p_sink) else $error("sink code wrong");
  a_thr: assert property (p_thr) else $error("threshold wrong");
  a_func: assert property (p_func) else $error("function defaults wrong");
  a_loop: assert property (p_loop) else $error("loop source wrong");
  a_drive: assert property (p_drive) else $error("current limit wrong");
  a_pin: assert property (p_pin) else $error("pin not high");
  c_thr: cover property (reg_wr && reg_addr == 4'h4);
  c_loop: cover property (loop_source_enable[0]);
  c_pin: cover property (channel_output_pin[0]);
endmodule // dic_channel_props
bind dic_channel_top dic_channel_props u_props (.core_clk(core_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sense_select(sense_select), .comparator_enable(comparator_enable),
  .sink_code(sink_code), .threshold_reference_select(threshold_reference_select),
  .threshold_code(threshold_code), .loop_source_enable(loop_source_enable),
  .loop_current_limit(loop_current_limit), .channel_output_pin(channel_output_pin));
`default_nettype wire

// ==== testbench/dic_sensor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dic_sensor_model (
  // clock
  input wire logic core_clk,
  // commanded level and contact chatter
  input wire logic [3:0] lvl,
  input wire logic bounce,
  // comparator results seen by the block
  output logic [3:0] unfiltered_terminal_sense = 4'h0,
  output logic [3:0] filtered_terminal_sense = 4'h0
);
  logic [2:0] ph_q = 3'h0;
  // raw path chatters faster than the sample tick; the filtered copy stays clean
  always @(posedge core_clk)
  begin
    ph_q <= ph_q + 3'h1;
    unfiltered_terminal_sense <= (bounce && ph_q[2]) ? ~lvl : lvl;
    filtered_terminal_sense <= lvl;
  end
endmodule // dic_sensor_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic bounce = 1'b0;
  logic [15:0] d;
  wire [15:0] reg_rdata, sink_code;
  wire [3:0] unfiltered_terminal_sense, filtered_terminal_sense, sense_select;
  wire [3:0] comparator_enable, loop_source_enable, channel_output_pin;
  wire threshold_reference_select;
  wire [4:0] threshold_code;
  wire [51:0] loop_current_limit;
  int n_fail = 0;
  int n_tests = 0;
  int took;
  always #2.5 core_clk = ~core_clk;
  dic_sensor_model PART (.core_clk, .lvl, .bounce, .unfiltered_terminal_sense,
    .filtered_terminal_sense);
  dic_channel_top DUT (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .unfiltered_terminal_sense, .filtered_terminal_sense, .sense_select,
    .comparator_enable, .sink_code, .threshold_reference_select, .threshold_code,
    .loop_source_enable, .loop_current_limit, .channel_output_pin);
  task automatic tally_and_finish(input bit hung);
    if (hung)
      n_fail++;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    #1 reg_wr <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    #1 d = reg_rdata;
    reg_rd <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int t, input int lo, input int hi);
    n_tests++;
    if (t < lo || t > hi)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h..%h", $time, t, lo, hi);
    end
  endtask
  // polls the state register; a long debounce is the only legal reason to wait
  task automatic wait_st(input logic v, input int lim);
    took = 0;
    rd(4'h6);
    while (d[0] !== v && took < lim)
    begin
      rd(4'h6);
      took += 2;
    end
    if (d[0] !== v)
      tally_and_finish(1);
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    rd(4'h0);
    chk(d, 16'h0000);
    rd(4'hF);
    chk(d, 16'h0000);
    $display("test reset done");
    wr(4'h0, 16'h1E80);
    chk({12'h0, sink_code[3:0]}, 16'h000F);
    chk({15'h0, sense_select[0]}, 16'h0001);
    wr(4'h4, 16'h001D);
    chk({10'h0, threshold_reference_select, threshold_code}, 16'h001D);
    wr(4'h4, 16'h003F);
    rd(4'h4);
    chk(d, 16'h003F);
    for (int f = 1; f < 3; f++)
    begin
      wr(4'h7, 16'(f));
      chk({14'h0, comparator_enable[0], loop_source_enable[0]}, 16'h2 | 16'(f >> 1));
      chk({12'h0, sink_code[3:0]}, 16'h0000);
    end
    wr(4'h8, 16'h1ABC);
    chk({3'h0, loop_current_limit[12:0]}, 16'h1ABC);
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h5, 16'h1 << (2 * c));
      chk({12'h0, channel_output_pin}, 16'h1 << c);
    end
    $display("test config done");
    wr(4'h5, 16'h0002);
    wr(4'h0, 16'h0100);
    lvl <= 4'h1;
    wait_st(1'b1, 400);
    chk_rng(took, 0, 170);
    chk({15'h0, channel_output_pin[0]}, 16'h0001);
    wr(4'h0, 16'h0140);
    wait_st(1'b0, 400);
    chk_rng(took, 0, 170);
    wr(4'h0, 16'h0180);
    bounce <= 1'b1;
    repeat (6)
    begin
      rd(4'h6);
      chk({15'h0, d[0]}, 16'h0001);
      repeat (53) @(posedge core_clk);
      #1;
    end
    bounce <= 1'b0;
    $display("test bypass done");
    for (int m = 0; m < 2; m++)
    begin
      lvl <= 4'h0;
      wr(4'h0, 16'h0101 | 16'(m << 5));
      wait_st(1'b0, 6000);
      lvl <= 4'h1;
      repeat (1600) @(posedge core_clk);
      #1;
      rd(4'h6);
      chk({15'h0, d[0]}, 16'h0000);
      lvl <= 4'h0;
      repeat (320) @(posedge core_clk);
      #1 lvl <= 4'h1;
      wait_st(1'b1, 4000);
      chk_rng(took, m ? 2240 : 800, m ? 2880 : 1760);
      $display("test debounce mode %0d done", m);
    end
    tally_and_finish(0);
  end
endmodule // tb_top
`default_nettype wire
